// *** include/cpp_pkg.sv ***
// Purpose: Constants and types for the partition and protection block
// Assumes: APB word registers, byte address = register index * 4
// Notes:   Configuration words erase to all ones
////////////////////////////////////////////////////////////////////////////////
package cpp_pkg;

  localparam logic [15:0] CPP_IDX_REV    = 16'h8005;
  localparam logic [15:0] CPP_IDX_PART   = 16'h8006;
  localparam logic [15:0] CPP_IDX_CFG4   = 16'h800a;
  localparam logic [15:0] CPP_IDX_CFG5   = 16'h800b;
  localparam logic [15:0] CPP_IDX_CTRL   = 16'h800c;
  localparam logic [15:0] CPP_IDX_STATUS = 16'h800d;

  localparam logic [15:0] CPP_CFG_ERASED  = 16'hffff;
  localparam logic [15:0] CPP_CFG4_STICKY = 16'h0f98;
  localparam logic [15:0] CPP_CFG5_STICKY = 16'h0003;

  localparam int          CPP_PROG_WORDS  = 8192;
  localparam int          CPP_SAF_WORDS   = 128;
  localparam logic [12:0] CPP_SAF_BASE    = 13'(CPP_PROG_WORDS - CPP_SAF_WORDS);
  localparam logic [12:0] CPP_BOOT_HALF   = 13'(CPP_PROG_WORDS / 2 - 1);
  localparam logic [14:0] CPP_PC_MASK     = 15'(CPP_PROG_WORDS - 1);
  localparam logic [14:0] CPP_RESET_VEC   = 15'h0000;
  localparam logic [14:0] CPP_IRQ_VEC     = 15'h0004;

  localparam logic [12:0] CPP_BOOT_END_7  = 13'h01ff;
  localparam logic [12:0] CPP_BOOT_END_6  = 13'h03ff;
  localparam logic [12:0] CPP_BOOT_END_5  = 13'h07ff;
  localparam logic [12:0] CPP_BOOT_END_4  = 13'h0fff;
  localparam logic [12:0] CPP_BOOT_END_3  = 13'h1fff;
  localparam logic [12:0] CPP_BOOT_END_LO = 13'h3fff;

  localparam logic [15:0] CPP_CFG_LO      = 16'h8007;
  localparam logic [15:0] CPP_CFG_HI      = 16'h800b;
  localparam logic [15:0] CPP_EEP_LO      = 16'hf000;
  localparam logic [15:0] CPP_EEP_HI      = 16'hf0ff;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       low_voltage_prog_en;
    logic       rsv_12;
    logic       storage_area_wprot;
    logic       eeprom_wprot;
    logic       config_wprot;
    logic       boot_region_wprot;
    logic       app_region_wprot;
    logic [1:0] rsv_mid;
    logic       storage_area_en_n;
    logic       boot_region_en_n;
    logic [2:0] boot_size_sel;
  } cpp_cfg4_s;

  typedef enum logic [2:0] {
    CPP_RG_APP  = 3'b000,
    CPP_RG_BOOT = 3'b001,
    CPP_RG_SAF  = 3'b010,
    CPP_RG_CFG  = 3'b011,
    CPP_RG_EEP  = 3'b100,
    CPP_RG_NONE = 3'b101
  } cpp_region_e;

  typedef enum logic {
    CPP_ST_LOAD = 1'b0,
    CPP_ST_RUN  = 1'b1
  } cpp_state_e;

endpackage

// *** logic/cpp_protect.sv ***
// Purpose: Flash partition, write/read protection, programming entry, PC
// Assumes: Single pclk domain; pins synchronised here
// Notes:   Config words live in nv registers; nv4 copied to holding after reset release, nv5 used directly
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module cpp_protect
  import cpp_pkg::*;
#(
  parameter logic [11:0] PART_CODE = 12'h0a5, // Arbitrary value
  parameter logic [5:0]  MAJOR_REV = 6'h01,   // Arbitrary value
  parameter logic [5:0]  MINOR_REV = 6'h02    // Arbitrary value
)(
  input  wire logic        pclk,              // Clock
  input  wire logic        presetn,           // Async reset, low
  input  wire logic        ce,                // Clock enable
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB direction
  input  wire logic [17:0] paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error
  input  wire logic        hv_detect_pin,     // High voltage on reset_progvolt_pin
  input  wire logic        lvp_key_pin,       // Low-voltage entry key seen
  input  wire logic        ext_reset_pin_en,  // Reset pin enable from other config
  output logic             reset_pin_is_reset,// Pin acts as reset
  output logic             lvp_entry_en,      // Low-voltage entry allowed
  output logic             prog_entry,        // Programming mode entered
  output logic             flash_read_prot,   // Program flash read protected
  output logic             eeprom_read_prot,  // EEPROM read protected
  input  wire logic        nvm_wr_req,        // NVM write check request
  input  wire logic [15:0] nvm_wr_addr,       // NVM write target
  output logic             nvm_wr_done,       // Check answer pulse
  output logic             nvm_wr_ok,         // Write allowed
  output logic             write_error_flag,  // Sticky write error
  input  wire logic        pc_step,           // Advance program counter
  input  wire logic        pc_load,           // Load jump target
  input  wire logic [14:0] pc_target,         // Jump target
  input  wire logic        irq_take,          // Vector to interrupt
  output logic      [14:0] fetch_addr,        // Wrapped program counter
  output logic             fetch_in_saf       // Fetch lies in STORAGE_AREA_FLASH
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  cpp_state_e  st;
  cpp_cfg4_s   nv4 = CPP_CFG_ERASED;
  logic [15:0] nv5 = CPP_CFG_ERASED;
  cpp_cfg4_s   hold4;
  logic        hv_s1;
  logic        hv_s2;
  logic        key_s1;
  logic        key_s2;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hv_s1  <= 1'b0;
      hv_s2  <= 1'b0;
      key_s1 <= 1'b0;
      key_s2 <= 1'b0;
    end
    else if (ce)
    begin
      hv_s1  <= hv_detect_pin;
      hv_s2  <= hv_s1;
      key_s1 <= lvp_key_pin;
      key_s2 <= key_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire logic [15:0] idx       = paddr[17:2];
  wire logic        aligned   = (paddr[1:0] == 2'b00);
  wire logic        sel_rev   = aligned && (idx == CPP_IDX_REV);
  wire logic        sel_part  = aligned && (idx == CPP_IDX_PART);
  wire logic        sel_cfg4  = aligned && (idx == CPP_IDX_CFG4);
  wire logic        sel_cfg5  = aligned && (idx == CPP_IDX_CFG5);
  wire logic        sel_ctrl  = aligned && (idx == CPP_IDX_CTRL);
  wire logic        sel_stat  = aligned && (idx == CPP_IDX_STATUS);
  wire logic        mapped    = sel_rev | sel_part | sel_cfg4 | sel_cfg5 | sel_ctrl | sel_stat;
  wire logic        setup     = psel && !penable;
  wire logic        acc       = psel && penable && pready;
  wire logic        wr_acc    = acc && pwrite && !pslverr;
  wire logic        bad_req   = !mapped || (pwrite && (sel_rev || sel_part));
  wire logic        lvp_session = prog_entry && hold4.low_voltage_prog_en;
  wire logic        cfg_locked  = !hold4.config_wprot;
  wire logic        cfg_wr      = wr_acc && (sel_cfg4 || sel_cfg5);
  wire logic        erase_go    = wr_acc && sel_ctrl && pwdata[0];

  wire logic [15:0] rev_word  = {2'b00, 1'b1, 1'b0, MAJOR_REV, MINOR_REV};
  wire logic [15:0] part_word = {2'b00, 2'b11, PART_CODE};
  wire logic [15:0] stat_word = {10'h000, st == CPP_ST_RUN, eeprom_read_prot, flash_read_prot,
                                 prog_entry, lvp_session, write_error_flag};
  wire logic [15:0] rd_word   = sel_rev  ? rev_word :
                                sel_part ? part_word :
                                sel_cfg4 ? nv4 :
                                sel_cfg5 ? nv5 :
                                sel_stat ? stat_word : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Config word write merge
  wire logic        lvp_keep  = lvp_session && !pwdata[13];
  wire logic [15:0] w4_sticky = nv4 & pwdata[15:0] & CPP_CFG4_STICKY;
  wire logic        w4_lvp    = lvp_keep ? nv4.low_voltage_prog_en : pwdata[13];
  wire logic [2:0]  w4_size   = nv4.boot_region_en_n ? pwdata[2:0] : nv4.boot_size_sel;
  wire logic [15:0] next_nv4  = (nv4 & ~CPP_CFG4_STICKY & 16'hdff8) | w4_sticky |
                                {2'b00, w4_lvp, 10'h000, w4_size};
  wire logic [15:0] next_nv5  = (nv5 & ~CPP_CFG5_STICKY) | (nv5 & pwdata[15:0] & CPP_CFG5_STICKY);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else if (ce)
    begin
      pready  <= setup;
      pslverr <= setup && bad_req;
      prdata  <= setup ? {16'h0000, rd_word} : 32'h00000000;
    end
  end

  // Nonvolatile words survive presetn; besides bulk erase, only writes to LOW_VOLTAGE_PROG_EN and boot_size_sel (boot region off) restore ones
  always_ff @(posedge pclk)
  begin
    if (ce)
    begin
      if (erase_go)
      begin
        nv4 <= CPP_CFG_ERASED;
        nv5 <= CPP_CFG_ERASED;
      end
      else if (cfg_wr && !cfg_locked && sel_cfg4)
        nv4 <= next_nv4;
      else if (cfg_wr && !cfg_locked && sel_cfg5)
        nv5 <= next_nv5;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Holding copy taken once after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st    <= CPP_ST_LOAD;
      hold4 <= CPP_CFG_ERASED;
    end
    else if (ce)
    begin
      case (st)
        CPP_ST_LOAD:
        begin
          hold4 <= nv4;
          st    <= CPP_ST_RUN;
        end
        CPP_ST_RUN:
          st <= CPP_ST_RUN;
        default:
          st <= CPP_ST_LOAD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Partition decode
  logic [12:0] boot_end_raw;

  always_comb
  begin
    case (hold4.boot_size_sel)
      3'b111:  boot_end_raw = CPP_BOOT_END_7;
      3'b110:  boot_end_raw = CPP_BOOT_END_6;
      3'b101:  boot_end_raw = CPP_BOOT_END_5;
      3'b100:  boot_end_raw = CPP_BOOT_END_4;
      3'b011:  boot_end_raw = CPP_BOOT_END_3;
      default: boot_end_raw = CPP_BOOT_END_LO;
    endcase
  end

  wire logic [12:0] boot_end  = (boot_end_raw > CPP_BOOT_HALF) ? CPP_BOOT_HALF : boot_end_raw;
  wire logic        boot_on   = !hold4.boot_region_en_n;
  wire logic        saf_on    = !hold4.storage_area_en_n;
  wire logic [12:0] wr_pfm    = nvm_wr_addr[12:0];
  wire logic        wr_in_pfm = !nvm_wr_addr[15];
  wire logic        wr_boot   = wr_in_pfm && boot_on && (wr_pfm <= boot_end);
  wire logic        wr_saf    = wr_in_pfm && saf_on && (wr_pfm >= CPP_SAF_BASE);
  wire logic        wr_cfg    = (nvm_wr_addr >= CPP_CFG_LO) && (nvm_wr_addr <= CPP_CFG_HI);
  wire logic        wr_eep    = (nvm_wr_addr >= CPP_EEP_LO) && (nvm_wr_addr <= CPP_EEP_HI);
  wire cpp_region_e wr_rg     = wr_boot   ? CPP_RG_BOOT :
                                wr_saf    ? CPP_RG_SAF :
                                wr_in_pfm ? CPP_RG_APP :
                                wr_cfg    ? CPP_RG_CFG :
                                wr_eep    ? CPP_RG_EEP : CPP_RG_NONE;
  wire logic        wr_prot   = ((wr_rg == CPP_RG_APP)  && !hold4.app_region_wprot)   ||
                                ((wr_rg == CPP_RG_BOOT) && !hold4.boot_region_wprot)  ||
                                ((wr_rg == CPP_RG_SAF)  && !hold4.storage_area_wprot) ||
                                ((wr_rg == CPP_RG_CFG)  && !hold4.config_wprot)       ||
                                ((wr_rg == CPP_RG_EEP)  && !hold4.eeprom_wprot)       ||
                                (wr_rg == CPP_RG_NONE);
  wire logic        chk_bad   = nvm_wr_req && (wr_prot || st != CPP_ST_RUN);
  wire logic        err_set   = chk_bad || (cfg_wr && cfg_locked);
  wire logic        err_clr   = wr_acc && sel_stat && pwdata[0];
  wire logic        next_err  = err_set || (write_error_flag && !err_clr);

  ////////////////////////////////////////////////////////////////////////////////
  // Protection and programming entry outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nvm_wr_done        <= 1'b0;
      nvm_wr_ok          <= 1'b0;
      write_error_flag   <= 1'b0;
      reset_pin_is_reset <= 1'b1;
      lvp_entry_en       <= 1'b0;
      prog_entry         <= 1'b0;
      flash_read_prot    <= 1'b0;
      eeprom_read_prot   <= 1'b0;
    end
    else if (ce)
    begin
      nvm_wr_done        <= nvm_wr_req;
      nvm_wr_ok          <= nvm_wr_req && !chk_bad;
      write_error_flag   <= next_err;
      reset_pin_is_reset <= hold4.low_voltage_prog_en || ext_reset_pin_en;
      lvp_entry_en       <= (st == CPP_ST_RUN) && hold4.low_voltage_prog_en;
      prog_entry         <= (st == CPP_ST_RUN) &&
                            (hold4.low_voltage_prog_en ? key_s2 : hv_s2);
      flash_read_prot    <= !nv5[0];
      eeprom_read_prot   <= !nv5[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Program counter
  wire logic [14:0] pc_raw  = irq_take ? CPP_IRQ_VEC :
                              pc_load  ? pc_target :
                              pc_step  ? 15'(fetch_addr + 15'h0001) : fetch_addr;
  wire logic [14:0] next_pc = pc_raw & CPP_PC_MASK;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_addr   <= CPP_RESET_VEC;
      fetch_in_saf <= 1'b0;
    end
    else if (ce)
    begin
      fetch_addr   <= next_pc;
      fetch_in_saf <= saf_on && (next_pc[12:0] >= CPP_SAF_BASE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_lvp_pin;
    ce && hold4.low_voltage_prog_en && st == CPP_ST_RUN |=> reset_pin_is_reset;
  endproperty
  a_lvp_pin: assert property (p_lvp_pin) else $error("Pin not reset in LOW_VOLTAGE_PROG_EN mode");

  property p_hv_entry;
    ce ##1 ce && !hold4.low_voltage_prog_en && !hv_s2 |=> !prog_entry;
  endproperty
  a_hv_entry: assert property (p_hv_entry) else $error("Entry without high voltage");

  property p_lvp_keep;
    ce && wr_acc && sel_cfg4 && lvp_session && nv4.low_voltage_prog_en && !pwdata[13]
      |=> nv4.low_voltage_prog_en;
  endproperty
  a_lvp_keep: assert property (p_lvp_keep) else $error("LOW_VOLTAGE_PROG_EN dropped in session");

  property p_wp_sticky;
    !nv4.app_region_wprot && !erase_go |=> !nv4.app_region_wprot;
  endproperty
  a_wp_sticky: assert property (p_wp_sticky) else $error("Write protect lifted");

  property p_cp_sticky;
    !nv5[0] && !erase_go |=> !nv5[0];
  endproperty
  a_cp_sticky: assert property (p_cp_sticky) else $error("Code protect lifted");

  property p_cp_now;
    ce && !nv5[0] |=> flash_read_prot;
  endproperty
  a_cp_now: assert property (p_cp_now) else $error("Code protect late");

  property p_wr_err;
    ce && nvm_wr_req && wr_prot |=> nvm_wr_done && !nvm_wr_ok && write_error_flag;
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("Protected write not flagged");

  property p_irq_vec;
    ce && irq_take |=> fetch_addr == 15'h0004;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("Bad interrupt vector");

  property p_boot_half;
    boot_end <= 13'h0fff;
  endproperty
  a_boot_half: assert property (p_boot_half) else $error("Boot block over half");

  property p_hold_stable;
    st == CPP_ST_RUN |=> $stable(hold4);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("Holding config changed");

  property p_wrap;
    fetch_addr[14:13] == 2'b00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("PC outside implemented memory");

endmodule

// *** test/cpp_nvm_model.sv ***
// Purpose: Write controller and programmer stand-in
// Assumes: Bench asks for checks and entry by level inputs
// Notes:   Released address shows inverted last value
`timescale 1ns/10ps
module cpp_nvm_model
  import cpp_pkg::*;
(
  input  wire logic        pclk,    // Clock
  input  wire logic        presetn, // Reset, low
  input  wire logic        go,      // Issue one check
  input  wire logic [15:0] go_addr, // Target of check
  input  wire logic        lv_mode, // Use low-voltage entry
  input  wire logic        enter,   // Hold programming entry
  output logic             req,     // Check request
  output logic      [15:0] addr,    // Check address
  output logic             hv_pin,  // High voltage applied
  output logic             key_pin  // Entry key applied
);
  assign hv_pin  = enter & ~lv_mode;
  assign key_pin = enter & lv_mode;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req  <= 1'b0;
      addr <= 16'h0000;
    end
    else
    begin
      req  <= go;
      addr <= go ? go_addr : ~addr;
    end
  end
endmodule

// *** test/cpp_protect_tb.sv ***
// Purpose: Self-checking bench for the partition and protection block
// Assumes: Zero-wait APB, expectations queued and popped by a monitor
// Notes:   Identity parameters set to arbitrary values
`timescale 1ns/10ps
module cpp_protect_tb
  import cpp_pkg::*;
  ();
  localparam logic [11:0] PART = 12'h5c3; // Arbitrary value
  localparam logic [5:0]  MAJ  = 6'h03;   // Arbitrary value
  localparam logic [5:0]  MIN  = 6'h11;   // Arbitrary value
  localparam logic [17:0] A_REV = {CPP_IDX_REV, 2'b00};
  localparam logic [17:0] A_PRT = {CPP_IDX_PART, 2'b00};
  localparam logic [17:0] A_C4  = {CPP_IDX_CFG4, 2'b00};
  localparam logic [17:0] A_C5  = {CPP_IDX_CFG5, 2'b00};
  localparam logic [17:0] A_CTL = {CPP_IDX_CTRL, 2'b00};
  localparam logic [17:0] A_STA = {CPP_IDX_STATUS, 2'b00};
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, lf = 32'h98d211fe;
  logic        pready, pslverr, hv, key, xre = 1'b0, rpr, lve, pe, frp, erp;
  logic        go = 1'b0, lvm = 1'b1, ent = 1'b0, req, done, ok, wef, step = 1'b0, load = 1'b0, irq = 1'b0, insaf;
  logic [15:0] go_a = '0, addr;
  logic [14:0] tgt = '0, fa, t;
  logic [33:0] e;
  logic [33:0] apb_q[$];
  logic        nvm_q[$];
  logic [2:0]  sz[6] = '{3'd7, 3'd6, 3'd5, 3'd4, 3'd3, 3'd0};
  int          n_fail = 0, total_checks = 0;

  always #20 pclk = ~pclk;

  cpp_protect #(.PART_CODE(PART), .MAJOR_REV(MAJ), .MINOR_REV(MIN)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hv_detect_pin(hv), .lvp_key_pin(key), .ext_reset_pin_en(xre), .reset_pin_is_reset(rpr),
    .lvp_entry_en(lve), .prog_entry(pe), .flash_read_prot(frp), .eeprom_read_prot(erp),
    .nvm_wr_req(req), .nvm_wr_addr(addr), .nvm_wr_done(done), .nvm_wr_ok(ok),
    .write_error_flag(wef), .pc_step(step), .pc_load(load), .pc_target(tgt), .irq_take(irq),
    .fetch_addr(fa), .fetch_in_saf(insaf));

  cpp_nvm_model u_nvm (.pclk(pclk), .presetn(presetn), .go(go), .go_addr(go_a), .lv_mode(lvm),
    .enter(ent), .req(req), .addr(addr), .hv_pin(hv), .key_pin(key));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  function automatic logic [15:0] bend(input logic [2:0] s);
    case (s)
      3'd7: return 16'h01ff;
      3'd6: return 16'h03ff;
      3'd5: return 16'h07ff;
      default: return 16'h0fff;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [33:0] x);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    apb_q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {2'b00, 32'h0});
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {2'b10, x});
  endtask

  task automatic idle;
    repeat (3) @(negedge pclk);
  endtask

  task automatic nvm(input logic [15:0] a, input logic x);
    nvm_q.push_back(x);
    @(posedge pclk);
    go <= 1'b1;
    go_a <= a;
    @(posedge pclk);
    go <= 1'b0;
    repeat (4) @(negedge pclk);
  endtask

  task automatic pins(input logic l, input logic n, input logic x);
    @(posedge pclk);
    lvm <= l;
    ent <= n;
    xre <= x;
    repeat (5) @(negedge pclk);
  endtask

  task automatic pc(input logic l, input logic s, input logic i, input logic [14:0] g, input logic [14:0] x);
    @(posedge pclk);
    load <= l;
    step <= s;
    irq <= i;
    tgt <= g;
    @(posedge pclk);
    load <= 1'b0;
    step <= 1'b0;
    irq <= 1'b0;
    repeat (2) @(negedge pclk);
    chk("fetch_addr", x, fa);
  endtask

  task automatic do_reset(input int n);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (n) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(negedge pclk);
  endtask

  task automatic tally_and_finish;
    chk("apb queue", 0, apb_q.size());
    chk("nvm queue", 0, nvm_q.size());
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scoreboard: oldest note against each answer
  always @(negedge pclk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      e = apb_q.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (e[33]) chk("prdata", e[31:0], prdata);
    end
    if (done === 1'b1) chk("nvm_wr_ok", {31'h0, nvm_q.pop_front()}, {31'h0, ok});
  end

  initial
  begin
    #400us;
    chk("watchdog", 0, 1);
    tally_and_finish;
  end

  initial
  begin
    do_reset(8);
    chk("fetch_addr", 0, fa);
    chk("lvp_entry_en", 1, lve);
    rd(A_PRT, {16'h0, 4'h3, PART});
    rd(A_REV, {16'h0, 4'h2, MAJ, MIN});
    apb(1'b1, A_PRT, 32'h0, {2'b01, 32'h0});
    apb(1'b0, A_C4 + 18'h1, 32'h0, {2'b01, 32'h0});
    apb(1'b0, 18'h20038, 32'h0, {2'b01, 32'h0});
    rd(A_C4, 32'hffff);
    pins(1'b1, 1'b1, 1'b0);
    chk("prog_entry", 1, pe);
    chk("reset_pin_is_reset", 1, rpr);
    wr(A_C4, 32'hdfff);
    rd(A_C4, 32'hffff);
    pins(1'b1, 1'b0, 1'b0);
    wr(A_C4, 32'hd6ee);
    wr(A_C4, 32'hd6e6);
    wr(A_C4, 32'hdff8);
    rd(A_C4, 32'hd6e6);
    nvm(16'h0100, 1);
    do_reset(2);
    $display("test lv session done");
    pins(1'b0, 1'b0, 1'b0);
    chk("lvp_entry_en", 0, lve);
    chk("reset_pin_is_reset", 0, rpr);
    pins(1'b1, 1'b1, 1'b1);
    chk("prog_entry", 0, pe);
    chk("reset_pin_is_reset", 1, rpr);
    pins(1'b0, 1'b1, 1'b0);
    chk("prog_entry", 1, pe);
    pins(1'b0, 1'b0, 1'b0);
    nvm(16'h03ff, 0);
    nvm(16'h0400, 1);
    nvm(16'h1f80, 0);
    nvm(16'h1f7f, 1);
    nvm(16'hf000, 1);
    nvm(16'h8007, 1);
    nvm(16'h9000, 0);
    nvm(16'h2100, 0);
    repeat (4) nvm(16'h0400 + 16'(rnd() % 32'h1b80), 1);
    chk("write_error_flag", 1, wef);
    wr(A_STA, 32'h1);
    idle;
    chk("write_error_flag", 0, wef);
    $display("test regions done");
    pc(1'b1, 1'b0, 1'b0, 15'h1f80, 15'h1f80);
    chk("fetch_in_saf", 1, insaf);
    pc(1'b1, 1'b0, 1'b0, 15'h1f7f, 15'h1f7f);
    chk("fetch_in_saf", 0, insaf);
    pc(1'b1, 1'b0, 1'b0, 15'h7fff, 15'h1fff);
    pc(1'b0, 1'b1, 1'b0, 15'h0, 15'h0000);
    pc(1'b0, 1'b0, 1'b1, 15'h0, 15'h0004);
    repeat (4)
    begin
      t = 15'(rnd());
      pc(1'b1, 1'b0, 1'b0, t, t & CPP_PC_MASK);
    end
    ce <= 1'b0;
    pc(1'b0, 1'b1, 1'b1, 15'h0, fa);
    ce <= 1'b1;
    $display("test counter done");
    wr(A_C5, 32'hfffe);
    idle;
    chk("flash_read_prot", 1, frp);
    chk("eeprom_read_prot", 0, erp);
    wr(A_C5, 32'hfffd);
    wr(A_C5, 32'hffff);
    idle;
    chk("flash_read_prot", 1, frp);
    chk("eeprom_read_prot", 1, erp);
    wr(A_CTL, 32'h1);
    idle;
    chk("flash_read_prot", 0, frp);
    $display("test read protect done");
    foreach (sz[i])
    begin
      wr(A_CTL, 32'h1);
      wr(A_C4, 32'hfef8 | 32'(sz[i]));
      wr(A_C4, 32'hfef0 | 32'(sz[i]));
      do_reset(2);
      nvm(bend(sz[i]), 0);
      nvm(bend(sz[i]) + 16'h1, 1);
    end
    wr(A_C4, 32'hfdff);
    do_reset(2);
    wr(A_C4, 32'h0);
    rd(A_C4, 32'hfcf0);
    nvm(16'h8007, 0);
    idle;
    chk("write_error_flag", 1, wef);
    $display("test boot sizes done");
    tally_and_finish;
  end
endmodule
